// ### rtl/isp_pkg.sv
package isp_pkg;
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_FLAG = 10'h00c;
    localparam logic [9:0] IDX_BUF = 10'h013;
    localparam logic [9:0] IDX_CTRL = 10'h014;
    localparam logic [9:0] IDX_DIR = 10'h087;
    localparam logic [9:0] IDX_IEN = 10'h08c;
    localparam logic [9:0] IDX_ADDR = 10'h093;
    localparam logic [9:0] IDX_STAT = 10'h094;
    // reset values
    localparam logic [7:0] RST_FLAG = 8'h00;
    localparam logic [7:0] RST_BUF = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam logic [7:0] RST_IEN = 8'h00;
    localparam logic [7:0] RST_ADDR = 8'h00;
    localparam logic [7:0] RST_STAT = 8'h00;
    // field positions
    localparam int FLAG_PORT_IRQ = 3;
    localparam int CTRL_WCOL = 7;
    localparam int CTRL_OV = 6;
    localparam int CTRL_EN = 5;
    localparam int CTRL_CKP = 4;
    localparam int STAT_DA = 5;
    localparam int STAT_STOP = 4;
    localparam int STAT_START = 3;
    localparam int STAT_RW = 2;
    localparam int STAT_UPD = 1;
    localparam int STAT_FULL = 0;
    localparam int DIR_SCL = 3;
    localparam int DIR_SDA = 4;
    // modes and constants
    localparam logic [3:0] MODE_SLV7 = 4'h6;
    localparam logic [3:0] MODE_SLV10 = 4'h7;
    localparam logic [3:0] MODE_SLV7_SS = 4'he;
    localparam logic [3:0] MODE_SLV10_SS = 4'hf;
    localparam logic [3:0] MODE_SS_ONLY = 4'hb;
    localparam logic [4:0] TENBIT_HDR = 5'h1e;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RECV = 3'h1,
        ST_ACK = 3'h3,
        ST_SEND = 3'h2,
        ST_MACK = 3'h6
    } isp_state_e;

    typedef enum logic [1:0] {
        PH_ADDR = 2'h0,
        PH_LOW = 2'h1,
        PH_DATA = 2'h2
    } isp_phase_e;

    function automatic logic isp_is_slave(input logic [3:0] m);
        return (m == MODE_SLV7) || (m == MODE_SLV10) || (m == MODE_SLV7_SS) ||
               (m == MODE_SLV10_SS);
    endfunction

    function automatic logic isp_is_ten(input logic [3:0] m);
        return (m == MODE_SLV10) || (m == MODE_SLV10_SS);
    endfunction

    function automatic logic isp_is_ss(input logic [3:0] m);
        return (m == MODE_SLV7_SS) || (m == MODE_SLV10_SS) || (m == MODE_SS_ONLY);
    endfunction
endpackage

// ### rtl/isp_slave_port.sv
`timescale 1ns/1ps
module isp_slave_port
    import isp_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // two-wire pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n
);
    // registers
    logic [7:0] flag_q, buf_q, ctrl_q, dir_q, ien_q, addr_q, stat_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, scl_oe_n_q, sda_oe_n_q;
    isp_state_e state_q;
    isp_phase_e phase_q;
    logic [3:0] bitcnt_q;
    logic [7:0] sr_q;
    logic ack_q, tx_pend_q, upd_pend_q, hi_ok_q, mack_q;
    logic [1:0] scl_sync_q, sda_sync_q;
    logic scl_q, sda_q;

    // line synchroniser and edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_q <= scl_sync_q[1];
            sda_q <= sda_sync_q[1];
        end
    end

    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    assign scl_s = scl_sync_q[1];
    assign sda_s = sda_sync_q[1];
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

    // apb decode, one wait state
    logic acc, wr_acc, rd_acc, hit;
    logic [9:0] idx;
    assign idx = paddr[11:2];
    assign acc = psel & penable & pready_q;
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;
    assign hit = (idx == IDX_FLAG) || (idx == IDX_BUF) || (idx == IDX_CTRL) ||
                 (idx == IDX_DIR) || (idx == IDX_IEN) || (idx == IDX_ADDR) ||
                 (idx == IDX_STAT);

    logic wr_flag, wr_buf, wr_ctrl, wr_dir, wr_ien, wr_addr, wr_stat, rd_buf;
    assign wr_flag = wr_acc & (idx == IDX_FLAG);
    assign wr_buf = wr_acc & (idx == IDX_BUF);
    assign wr_ctrl = wr_acc & (idx == IDX_CTRL);
    assign wr_dir = wr_acc & (idx == IDX_DIR);
    assign wr_ien = wr_acc & (idx == IDX_IEN);
    assign wr_addr = wr_acc & (idx == IDX_ADDR);
    assign wr_stat = wr_acc & (idx == IDX_STAT);
    assign rd_buf = rd_acc & (idx == IDX_BUF);

    logic en, slave_on, ten, ss_on, buf_full, ov, ckp;
    assign en = ctrl_q[CTRL_EN];
    assign slave_on = en & isp_is_slave(ctrl_q[3:0]);
    assign ten = isp_is_ten(ctrl_q[3:0]);
    assign ss_on = en & isp_is_ss(ctrl_q[3:0]);
    assign buf_full = stat_q[STAT_FULL];
    assign ov = ctrl_q[CTRL_OV];
    assign ckp = ctrl_q[CTRL_CKP];

    // byte end decisions
    logic byte_end, accept, room, ack_ok, rw_in, is_hi_rd;
    assign byte_end = (state_q == ST_RECV) && scl_fall && (bitcnt_q == BYTE_BITS);
    assign rw_in = sr_q[0];
    assign room = ~buf_full & ~ov;
    always_comb begin
        accept = 1'b0;
        is_hi_rd = 1'b0;
        unique case (phase_q)
            PH_ADDR: begin
                if (ten) begin
                    if ((sr_q[7:3] == TENBIT_HDR) && (sr_q[2:1] == addr_q[2:1])) begin
                        accept = ~rw_in | hi_ok_q;
                        is_hi_rd = rw_in;
                    end
                end else begin
                    accept = (sr_q[7:1] == addr_q[7:1]) && (sr_q[7:1] != 7'h00);
                end
            end
            PH_LOW: accept = (sr_q == addr_q);
            default: accept = 1'b1;
        endcase
    end
    assign ack_ok = accept & room;

    // events toward the registers
    logic ev_flag, ev_load, ev_ov, ev_upd, ev_hold, ev_nack, ev_wcol;
    assign ev_load = byte_end & ack_ok;
    assign ev_ov = byte_end & accept & buf_full;
    assign ev_upd = (state_q == ST_ACK) && scl_fall && upd_pend_q;
    assign ev_hold = scl_fall && (((state_q == ST_ACK) && tx_pend_q) ||
                     ((state_q == ST_MACK) && !mack_q));
    assign ev_nack = (state_q == ST_MACK) && scl_rise && sda_s;
    assign ev_wcol = wr_buf && (state_q == ST_SEND) && ckp;
    assign ev_flag = (scl_fall && ((state_q == ST_ACK) ||
                     ((state_q == ST_MACK) && !mack_q))) ||
                     (ss_on && (start_det || stop_det));

    // slave engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            phase_q <= PH_ADDR;
            bitcnt_q <= 4'h0;
            sr_q <= 8'h00;
            ack_q <= 1'b0;
            tx_pend_q <= 1'b0;
            upd_pend_q <= 1'b0;
            hi_ok_q <= 1'b0;
            mack_q <= 1'b1;
        end else if (!slave_on) begin
            state_q <= ST_IDLE;
            hi_ok_q <= 1'b0;
        end else if (start_det) begin
            state_q <= ST_RECV;
            phase_q <= PH_ADDR;
            bitcnt_q <= 4'h0;
        end else if (stop_det) begin
            state_q <= ST_IDLE;
            hi_ok_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (wr_buf) begin
                        sr_q <= pwdata[7:0];
                    end
                end
                ST_RECV: begin
                    if (scl_rise && (bitcnt_q < BYTE_BITS)) begin
                        sr_q <= {sr_q[6:0], sda_s};
                        bitcnt_q <= bitcnt_q + 4'h1;
                    end else if (byte_end) begin
                        state_q <= accept ? ST_ACK : ST_IDLE;
                        ack_q <= ack_ok;
                        tx_pend_q <= (phase_q == PH_ADDR) && rw_in && accept;
                        upd_pend_q <= ten && (phase_q != PH_DATA) && !is_hi_rd;
                        if (phase_q == PH_LOW) begin
                            hi_ok_q <= accept;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bitcnt_q <= 4'h0;
                        ack_q <= 1'b0;
                        if (tx_pend_q) begin
                            state_q <= ST_SEND;
                        end else begin
                            state_q <= ST_RECV;
                            if (phase_q == PH_ADDR && ten) begin
                                phase_q <= PH_LOW;
                            end else begin
                                phase_q <= PH_DATA;
                            end
                        end
                    end
                end
                ST_SEND: begin
                    if (wr_buf && !ckp) begin
                        sr_q <= pwdata[7:0];
                    end else if (scl_fall && ckp) begin
                        sr_q <= {sr_q[6:0], 1'b1};
                        bitcnt_q <= bitcnt_q + 4'h1;
                        if (bitcnt_q == BYTE_BITS - 4'h1) begin
                            state_q <= ST_MACK;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        mack_q <= sda_s;
                        if (sda_s) begin
                            state_q <= ST_IDLE;
                        end
                    end else if (scl_fall) begin
                        state_q <= ST_SEND;
                        bitcnt_q <= 4'h0;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_q <= RST_BUF;
        end else if (ev_load) begin
            buf_q <= sr_q;
        end else if (wr_buf && !ev_wcol) begin
            buf_q <= pwdata[7:0];
        end
    end

    // control: hardware sets win over firmware writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= RST_CTRL;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[7:0];
            end
            if (ev_ov) begin
                ctrl_q[CTRL_OV] <= 1'b1;
            end
            if (ev_wcol) begin
                ctrl_q[CTRL_WCOL] <= 1'b1;
            end
            if (ev_hold) begin
                ctrl_q[CTRL_CKP] <= 1'b0;
            end
        end
    end

    // status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= RST_STAT;
        end else if (!en || ev_nack) begin
            stat_q <= RST_STAT;
        end else begin
            if (wr_stat) begin
                stat_q[7:6] <= pwdata[7:6];
            end
            if (rd_buf) begin
                stat_q[STAT_FULL] <= 1'b0;
            end
            if (wr_addr) begin
                stat_q[STAT_UPD] <= 1'b0;
            end
            if (start_det) begin
                stat_q[STAT_START] <= 1'b1;
                stat_q[STAT_STOP] <= 1'b0;
            end
            if (stop_det) begin
                stat_q[STAT_STOP] <= 1'b1;
                stat_q[STAT_START] <= 1'b0;
            end
            if (byte_end && accept) begin
                stat_q[STAT_DA] <= (phase_q == PH_DATA);
                if (phase_q == PH_ADDR) begin
                    stat_q[STAT_RW] <= rw_in;
                end
            end
            if (ev_load) begin
                stat_q[STAT_FULL] <= 1'b1;
            end
            if (ev_upd) begin
                stat_q[STAT_UPD] <= 1'b1;
            end
        end
    end

    // plain storage registers and interrupt flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= RST_FLAG;
            dir_q <= RST_DIR;
            ien_q <= RST_IEN;
            addr_q <= RST_ADDR;
        end else begin
            if (wr_flag) begin
                flag_q <= pwdata[7:0];
            end
            if (ev_flag) begin
                flag_q[FLAG_PORT_IRQ] <= 1'b1;
            end
            if (wr_dir) begin
                dir_q <= pwdata[7:0];
            end
            if (wr_ien) begin
                ien_q <= pwdata[7:0];
            end
            if (wr_addr) begin
                addr_q <= pwdata[7:0];
            end
        end
    end

    // apb answer
    logic [7:0] rd_mux;
    always_comb begin
        unique case (idx)
            IDX_FLAG: rd_mux = flag_q;
            IDX_BUF: rd_mux = buf_q;
            IDX_CTRL: rd_mux = ctrl_q;
            IDX_DIR: rd_mux = dir_q;
            IDX_IEN: rd_mux = ien_q;
            IDX_ADDR: rd_mux = addr_q;
            IDX_STAT: rd_mux = stat_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~hit;
            prdata_q <= (psel & ~pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    // open-drain pins, low while driving
    logic scl_low_d, sda_low_d, i2c_on;
    assign i2c_on = en & (isp_is_slave(ctrl_q[3:0]) | isp_is_ss(ctrl_q[3:0]));
    assign scl_low_d = ~dir_q[DIR_SCL] | (i2c_on & dir_q[DIR_SCL] &
                       (stat_q[STAT_UPD] | ((state_q == ST_SEND) & ~ckp)));
    assign sda_low_d = ~dir_q[DIR_SDA] | (i2c_on & dir_q[DIR_SDA] &
                       (((state_q == ST_ACK) & ack_q) |
                       ((state_q == ST_SEND) & ~sr_q[7])));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
        end else begin
            scl_oe_n_q <= ~scl_low_d;
            sda_oe_n_q <= ~sda_low_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_n = scl_oe_n_q;
    assign sda_oe_n = sda_oe_n_q;

    // checks
    AST_NO_GCALL: assert property (@(posedge pclk) disable iff (!presetn)
        byte_end && (phase_q == PH_ADDR) && !ten && (sr_q[7:1] == 7'h00) |=> state_q == ST_IDLE)
        else $error("general call address answered");
    AST_ACK_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        byte_end && ack_ok && slave_on && !start_det && !stop_det |=>
        stat_q[STAT_FULL] && (buf_q == $past(sr_q)) && (state_q == ST_ACK) ##1 !sda_oe_n_q)
        else $error("matched byte not loaded and acknowledged");
    AST_NO_ACK_FULL: assert property (@(posedge pclk) disable iff (!presetn)
        byte_end && accept && (buf_full || ov) |=>
        !ack_q && (buf_q == $past(buf_q) || $past(wr_buf)))
        else $error("byte taken while buffer full or overflow");
    AST_FLAG_9TH: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_ACK) && scl_fall && slave_on |=> flag_q[FLAG_PORT_IRQ])
        else $error("flag not set on ninth clock fall");
    AST_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
        !en |=> (state_q == ST_IDLE) && (stat_q == RST_STAT))
        else $error("port active while disabled");
    AST_FULL_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        rd_buf && !ev_load |=> !stat_q[STAT_FULL])
        else $error("buffer read did not clear full flag");
    AST_OV_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        ov && !wr_ctrl |=> ov)
        else $error("overflow cleared itself");
    AST_UPD_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_addr && !ev_upd && en && (state_q != ST_SEND) && dir_q[DIR_SCL] |=>
        !stat_q[STAT_UPD] ##1 scl_oe_n_q)
        else $error("address write did not release clock");
    AST_START_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        start_det && ss_on |=> flag_q[FLAG_PORT_IRQ] && stat_q[STAT_START])
        else $error("start interrupt missing");
    AST_SHIFT: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_RECV) && scl_rise && (bitcnt_q < BYTE_BITS) && slave_on &&
        !start_det && !stop_det |=> (sr_q[0] == $past(sda_s)) && (bitcnt_q == $past(bitcnt_q) + 4'h1))
        else $error("bit not shifted on clock rise");

    COV_ADDR_ACK: cover property (@(posedge pclk) disable iff (!presetn) byte_end && ack_ok);
    COV_OVERFLOW: cover property (@(posedge pclk) disable iff (!presetn) ev_ov);
    COV_TEN_UPD: cover property (@(posedge pclk) disable iff (!presetn) ev_upd ##[1:1000] wr_addr);
    COV_SEND: cover property (@(posedge pclk) disable iff (!presetn) state_q == ST_MACK);
endmodule

// ### verification/isp_bus_master.sv
`timescale 1ns/1ps
module isp_bus_master (
    // bus lines
    input wire logic scl_w,
    input wire logic sda_w,
    output logic scl_m,
    output logic sda_m
);
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    // raise clock, wait while slave stretches
    task automatic clk_hi();
        scl_m = 1'b1;
        while (scl_w !== 1'b1) begin
            #40;
        end
    endtask
    task automatic start();
        sda_m = 1'b1;
        #100;
        clk_hi();
        #160;
        sda_m = 1'b0;
        #160;
        scl_m = 1'b0;
        #60;
    endtask
    task automatic stop();
        sda_m = 1'b0;
        #100;
        clk_hi();
        #160;
        sda_m = 1'b1;
        #320;
    endtask
    // eight bits msb first, ninth clock samples ack
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_m = (i == 0) ? 1'b1 : b[i - 1];
            #100;
            clk_hi();
            #120;
            ack = ~sda_w;
            #40;
            scl_m = 1'b0;
            #60;
        end
        #200;
    endtask
    // eight bits read while clock high, ninth clock gives ack or not
    task automatic recv(input logic nack, output logic [7:0] b);
        b = 8'h00;
        for (int i = 8; i >= 0; i--) begin
            sda_m = (i == 0) ? nack : 1'b1;
            #100;
            clk_hi();
            #120;
            if (i > 0) begin
                b = {b[6:0], sda_w};
            end
            #40;
            scl_m = 1'b0;
            #60;
        end
        sda_m = 1'b1;
        #200;
    endtask
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    import isp_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, perr, scl_o, scl_oe_n, sda_o, sda_oe_n, scl_m, sda_m, ack;
    wire logic scl_w = scl_m & (scl_oe_n | scl_o);
    wire logic sda_w = sda_m & (sda_oe_n | sda_o);
    int num_errors = 0;
    int cmp_count = 0;
    always #20 pclk = ~pclk;
    isp_slave_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
    isp_bus_master i_mst (.scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [9:0] idx, input logic [7:0] m, e);
        apb(1'b0, idx, 8'h00);
        chk(nm, rd & {24'h00_0000, m}, {24'h00_0000, e});
    endtask
    // direction register never written: both pins stay inputs
    task automatic t_regs();
        logic [9:0] ix [7] = '{IDX_FLAG, IDX_BUF, IDX_CTRL, IDX_DIR, IDX_IEN, IDX_ADDR, IDX_STAT};
        logic [7:0] rv [7] = '{RST_FLAG, RST_BUF, RST_CTRL, RST_DIR, RST_IEN, RST_ADDR, RST_STAT};
        for (int i = 0; i < 7; i++) begin
            rdc("reset", ix[i], 8'hff, rv[i]);
        end
        apb(1'b0, 10'h001, 8'h00);
        chk("unmapped", {perr, rd[7:0]}, 32'h0000_0100);
    endtask
    task automatic t_rx7();
        apb(1'b1, IDX_ADDR, 8'ha4);
        apb(1'b1, IDX_CTRL, 8'h26);
        i_mst.start();
        i_mst.send(8'ha4, ack);
        chk("addr ack", ack, 1);
        rdc("full", IDX_STAT, 8'h01, 8'h01);
        rdc("flag", IDX_FLAG, 8'h08, 8'h08);
        rdc("buf", IDX_BUF, 8'hff, 8'ha4);
        rdc("full clr", IDX_STAT, 8'h01, 8'h00);
        apb(1'b1, IDX_FLAG, 8'h00);
        i_mst.send(8'h3c, ack);
        chk("data ack", ack, 1);
        apb(1'b1, IDX_FLAG, 8'h00);
        i_mst.send(8'h5a, ack);
        chk("full nack", ack, 0);
        rdc("ov", IDX_CTRL, 8'h40, 8'h40);
        rdc("flag", IDX_FLAG, 8'h08, 8'h08);
        rdc("buf kept", IDX_BUF, 8'hff, 8'h3c);
        i_mst.send(8'h77, ack);
        chk("ov nack", ack, 0);
        rdc("ov stays", IDX_CTRL, 8'h40, 8'h40);
        rdc("buf kept", IDX_BUF, 8'hff, 8'h3c);
        i_mst.stop();
    endtask
    task automatic t_none();
        logic [7:0] cv [3] = '{8'h26, 8'h26, 8'h06};
        logic [7:0] sv [3] = '{8'h00, 8'ha4, 8'ha4};
        logic [7:0] av [3] = '{8'h00, 8'ha6, 8'ha4};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, IDX_CTRL, cv[i]);
            apb(1'b1, IDX_ADDR, sv[i]);
            apb(1'b1, IDX_FLAG, 8'h00);
            i_mst.start();
            i_mst.send(av[i], ack);
            i_mst.stop();
            chk("no ack", ack, 0);
            rdc("no flag", IDX_FLAG, 8'h08, 8'h00);
        end
    endtask
    task automatic t_ten();
        apb(1'b1, IDX_CTRL, 8'h27);
        apb(1'b1, IDX_ADDR, 8'hf4);
        apb(1'b1, IDX_FLAG, 8'h00);
        i_mst.start();
        i_mst.send(8'hf4, ack);
        chk("hi ack", ack, 1);
        rdc("hi upd", IDX_STAT, 8'h03, 8'h03);
        rdc("hi flag", IDX_FLAG, 8'h08, 8'h08);
        chk("scl held", scl_oe_n, 0);
        apb(1'b1, IDX_ADDR, 8'hb5);
        rdc("upd clr", IDX_STAT, 8'h02, 8'h00);
        chk("scl free", scl_oe_n, 1);
        apb(1'b0, IDX_BUF, 8'h00);
        apb(1'b1, IDX_FLAG, 8'h00);
        i_mst.send(8'hb5, ack);
        chk("lo ack", ack, 1);
        rdc("lo upd", IDX_STAT, 8'h03, 8'h03);
        apb(1'b1, IDX_ADDR, 8'hf4);
        rdc("lo buf", IDX_BUF, 8'hff, 8'hb5);
        chk("scl free", scl_oe_n, 1);
        i_mst.send(8'h99, ack);
        i_mst.stop();
        chk("d ack", ack, 1);
        rdc("d buf", IDX_BUF, 8'hff, 8'h99);
    endtask
    task automatic t_tx();
        logic [7:0] rb;
        apb(1'b1, IDX_CTRL, 8'h36);
        apb(1'b1, IDX_ADDR, 8'ha4);
        apb(1'b1, IDX_FLAG, 8'h00);
        i_mst.start();
        i_mst.send(8'ha5, ack);
        chk("rd addr ack", ack, 1);
        rdc("rw full", IDX_STAT, 8'h05, 8'h05);
        rdc("rd flag", IDX_FLAG, 8'h08, 8'h08);
        chk("scl stretch", scl_oe_n, 0);
        apb(1'b0, IDX_BUF, 8'h00);
        apb(1'b1, IDX_BUF, 8'h6c);
        apb(1'b1, IDX_CTRL, 8'h36);
        i_mst.recv(1'b1, rb);
        chk("tx byte", rb, 8'h6c);
        rdc("nack reset", IDX_STAT, 8'hff, 8'h00);
        i_mst.stop();
    endtask
    task automatic t_ss();
        logic [3:0] mv [3] = '{MODE_SS_ONLY, MODE_SLV7_SS, MODE_SLV10_SS};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, IDX_CTRL, {4'h2, mv[i]});
            apb(1'b1, IDX_FLAG, 8'h00);
            i_mst.start();
            rdc("start", IDX_FLAG, 8'h08, 8'h08);
            rdc("s bit", IDX_STAT, 8'h18, 8'h08);
            apb(1'b1, IDX_FLAG, 8'h00);
            i_mst.stop();
            rdc("stop", IDX_FLAG, 8'h08, 8'h08);
            rdc("p bit", IDX_STAT, 8'h18, 8'h10);
        end
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_rx7();
        t_none();
        t_ten();
        t_tx();
        t_ss();
        print_verdict();
    end
endmodule
